// ### hw/edt_timer.v
/*
 Event-triggered 8-bit down timer with its register file and interrupt.
 Assumes a register master on clk_sys_i with one-cycle strobes, and
 transceive event inputs that are one-cycle pulses synchronous to clk_sys_i.
*/
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`include "edt_map.vh"

module edt_timer (
    // Clock and reset
    input wire clk_sys_i,
    input wire nrst_i,

    // Register port
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,

    // Transceive events
    input wire tx_begin_i,
    input wire tx_end_i,
    input wire rx_begin_i,
    input wire rx_end_i,

    // Timer state
    output reg [7:0] current_count_o,
    output reg count_active_o,

    // Interrupt
    output reg irq_o
);

// ----------------------------------------
// States
// ----------------------------------------
localparam ST_IDLE = 2'b01;
localparam ST_COUNT = 2'b10;

// ----------------------------------------
// Reset and end-of-count values
// ----------------------------------------
localparam [5:0] RST_CFG = `EDT_RST_CLOCK_CFG;
localparam [7:0] LAST_COUNT = 8'h01;

// ----------------------------------------
// Address match
// ----------------------------------------
function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
        hit = (addr == offset);
    end
endfunction

// ----------------------------------------
// Last count before the end
// ----------------------------------------
function at_end;
    input [7:0] count;
    begin
        at_end = (count <= LAST_COUNT);
    end
endfunction

// ----------------------------------------
// Declarations
// ----------------------------------------
reg [1:0] state;
reg [1:0] next_state;
reg [7:0] next_count;
reg zero_evt;
reg stop_done;
reg start_done;

reg auto_restart;
reg [4:0] tick_prescale_exp;
reg [3:0] trigger_ctrl;
reg [7:0] start_value;
reg [`EDT_IRQ_WIDTH-1:0] irq_mask;

reg [7:0] next_rdata;

wire wr_control;
wire wr_clock_cfg;
wire wr_trigger;
wire wr_start_value;
wire wr_irq_status;
wire wr_irq_mask;

wire immediate_start;
wire immediate_stop;
wire go_on_send_begin;
wire trigger_on_send_end;
wire go_on_receive_begin;
wire halt_on_receive_end;
wire start_evt;
wire stop_evt;

wire tick;
wire prescale_clear;
wire [`EDT_IRQ_WIDTH-1:0] irq_set;
wire [`EDT_IRQ_WIDTH-1:0] irq_clr;
wire [`EDT_IRQ_WIDTH-1:0] irq_status;
wire [`EDT_IRQ_WIDTH-1:0] irq_pending;

// ----------------------------------------
// Write decode
// ----------------------------------------
assign wr_control = wr_i && hit(addr_i, `EDT_ADDR_CONTROL);
assign wr_clock_cfg = wr_i && hit(addr_i, `EDT_ADDR_CLOCK_CFG);
assign wr_trigger = wr_i && hit(addr_i, `EDT_ADDR_TRIGGER);
assign wr_start_value = wr_i && hit(addr_i, `EDT_ADDR_START_VALUE);
assign wr_irq_status = wr_i && hit(addr_i, `EDT_ADDR_IRQ_STATUS);
assign wr_irq_mask = wr_i && hit(addr_i, `EDT_ADDR_IRQ_MASK);

// ----------------------------------------
// Start and stop sources
// ----------------------------------------
assign immediate_start = wr_control && wdata_i[`EDT_CTRL_START_BIT];
assign immediate_stop = wr_control && wdata_i[`EDT_CTRL_STOP_BIT];

assign go_on_send_begin = trigger_ctrl[`EDT_TRG_TX_BEGIN_BIT] && tx_begin_i;
assign trigger_on_send_end = trigger_ctrl[`EDT_TRG_TX_END_BIT] && tx_end_i;
assign go_on_receive_begin = trigger_ctrl[`EDT_TRG_RX_BEGIN_BIT] && rx_begin_i;
assign halt_on_receive_end = trigger_ctrl[`EDT_TRG_RX_END_BIT] && rx_end_i;

assign start_evt = immediate_start
                 || go_on_send_begin
                 || trigger_on_send_end
                 || go_on_receive_begin;

assign stop_evt = immediate_stop || halt_on_receive_end;

// ----------------------------------------
// Tick generator
// ----------------------------------------
assign prescale_clear = (state != ST_COUNT) || start_evt;

edt_prescaler edt_prescaler_i (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .clear_i(prescale_clear),
    .exp_i(tick_prescale_exp),
    .tick_o(tick)
);

// ----------------------------------------
// Counter state machine
// ----------------------------------------
always @*
begin
    next_state = state;
    next_count = current_count_o;
    zero_evt = 1'b0;
    stop_done = 1'b0;
    start_done = 1'b0;
    case (state)
        ST_IDLE:
        begin
            if (start_evt && !stop_evt)
            begin
                next_state = ST_COUNT;
                next_count = start_value;
                start_done = 1'b1;
            end
        end
        ST_COUNT:
        begin
            if (stop_evt)
            begin
                next_state = ST_IDLE;
                stop_done = 1'b1;
            end
            else if (start_evt)
            begin
                next_count = start_value;
                start_done = 1'b1;
            end
            else if (tick)
            begin
                if (auto_restart && at_end(current_count_o))
                begin
                    next_count = start_value;
                    zero_evt = 1'b1;
                end
                else if (at_end(current_count_o))
                begin
                    next_count = 8'h00;
                    next_state = ST_IDLE;
                    zero_evt = 1'b1;
                end
                else
                begin
                    next_count = current_count_o - 8'h01;
                end
            end
        end
        default:
        begin
            next_state = ST_IDLE;
        end
    endcase
end

// ----------------------------------------
// Counter registers
// ----------------------------------------

always @(posedge clk_sys_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        state <= ST_IDLE;
        current_count_o <= `EDT_RST_COUNT;
        count_active_o <= 1'b0;
    end
    else
    begin
        state <= next_state;
        current_count_o <= next_count;
        count_active_o <= (next_state == ST_COUNT);
    end
end

// ----------------------------------------
// Configuration registers
// ----------------------------------------
always @(posedge clk_sys_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        auto_restart <= RST_CFG[`EDT_CFG_RESTART_BIT];
        tick_prescale_exp <= RST_CFG[`EDT_CFG_EXP_MSB:0];
        trigger_ctrl <= `EDT_RST_TRIGGER;
        start_value <= `EDT_RST_START_VALUE;
        irq_mask <= `EDT_RST_IRQ_MASK;
    end
    else
    begin
        if (wr_clock_cfg)
        begin
            auto_restart <= wdata_i[`EDT_CFG_RESTART_BIT];
            tick_prescale_exp <= wdata_i[`EDT_CFG_EXP_MSB:0];
        end
        if (wr_trigger)
        begin
            trigger_ctrl <= wdata_i[3:0];
        end
        if (wr_start_value)
        begin
            start_value <= wdata_i;
        end
        if (wr_irq_mask)
        begin
            irq_mask <= wdata_i[`EDT_IRQ_WIDTH-1:0];
        end
    end
end

// ----------------------------------------
// Interrupt flags
// ----------------------------------------
assign irq_set = {stop_done, start_done, zero_evt};
assign irq_clr = wr_irq_status ? wdata_i[`EDT_IRQ_WIDTH-1:0] : {`EDT_IRQ_WIDTH{1'b0}};
assign irq_pending = irq_status & irq_mask;

edt_flag_bank edt_flag_bank_i (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .set_i(irq_set),
    .clr_i(irq_clr),
    .flag_o(irq_status)
);

always @(posedge clk_sys_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        irq_o <= 1'b0;
    end
    else
    begin
        irq_o <= |irq_pending;
    end
end

// ----------------------------------------
// Read port
// ----------------------------------------
always @*
begin
    next_rdata = 8'h00;
    if (hit(addr_i, `EDT_ADDR_COUNT))
    begin
        next_rdata = current_count_o;
    end
    else if (hit(addr_i, `EDT_ADDR_CLOCK_CFG))
    begin
        next_rdata = {2'b00, auto_restart, tick_prescale_exp};
    end
    else if (hit(addr_i, `EDT_ADDR_TRIGGER))
    begin
        next_rdata = {4'h0, trigger_ctrl};
    end
    else if (hit(addr_i, `EDT_ADDR_START_VALUE))
    begin
        next_rdata = start_value;
    end
    else if (hit(addr_i, `EDT_ADDR_STATUS))
    begin
        next_rdata = {7'h00, count_active_o};
    end
    else if (hit(addr_i, `EDT_ADDR_IRQ_STATUS))
    begin
        next_rdata = {5'h00, irq_status};
    end
    else if (hit(addr_i, `EDT_ADDR_IRQ_MASK))
    begin
        next_rdata = {5'h00, irq_mask};
    end
end

// ----------------------------------------
// Read data register
// ----------------------------------------

always @(posedge clk_sys_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        rdata_o <= 8'h00;
    end
    else if (rd_i)
    begin
        rdata_o <= next_rdata;
    end
    else
    begin
        rdata_o <= 8'h00;
    end
end

endmodule

// ### hw/edt_map.vh
/*
 Holds the register offsets, field positions, reset values and timing
 constants of the event-triggered down timer.
 Assumes it is included by bare name from every design file of the timer.
*/
// Functional notes
// - With auto_restart set, reload start_value after each count and keep counting.
// - With auto_restart set, reload at count 1 instead of reaching zero.
// - Clock config bits 4..0 hold the tick prescale exponent.
// - One tick lasts two to the exponent reference cycles; exponent 0..21.
// - Start value register at 0x2C is copied into the count on start.
// - Current count readable at 0x0C at any time.
// - Count falls by exactly one per tick.
// - Writing immediate_start loads start value and starts counting.
// - Writing immediate_stop halts counting and freezes the count.
// - Trigger bit 3 stops the timer when reception ends.
// - Trigger bit 2 starts the timer when reception begins.
// - Trigger bit 1 starts the timer when transmission ends.
// - Trigger bit 0 starts the timer when transmission begins.
// - Running flag set on start event, cleared on stop event or when the count ends at zero without auto_restart.
// - Zero request raised on the tick at count 1, whether the count then goes to zero or reloads.
// - Zero request sticks until cleared; drives interrupt only when enabled.
// - Event bits set by hardware and held until software clears them.
`ifndef EDT_MAP_VH
`define EDT_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EDT_ADDR_CONTROL 8'h09
`define EDT_ADDR_COUNT 8'h0C
`define EDT_ADDR_CLOCK_CFG 8'h2A
`define EDT_ADDR_TRIGGER 8'h2B
`define EDT_ADDR_START_VALUE 8'h2C
`define EDT_ADDR_STATUS 8'h30
`define EDT_ADDR_IRQ_STATUS 8'h31
`define EDT_ADDR_IRQ_MASK 8'h32

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EDT_CTRL_START_BIT 0
`define EDT_CTRL_STOP_BIT 1
`define EDT_CFG_RESTART_BIT 5
`define EDT_CFG_EXP_MSB 4
`define EDT_TRG_TX_BEGIN_BIT 0
`define EDT_TRG_TX_END_BIT 1
`define EDT_TRG_RX_BEGIN_BIT 2
`define EDT_TRG_RX_END_BIT 3
`define EDT_IRQ_ZERO_BIT 0
`define EDT_IRQ_START_BIT 1
`define EDT_IRQ_STOP_BIT 2
`define EDT_IRQ_WIDTH 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EDT_RST_COUNT 8'h05
`define EDT_RST_CLOCK_CFG 6'h07
`define EDT_RST_TRIGGER 4'h6
`define EDT_RST_START_VALUE 8'h0A
`define EDT_RST_IRQ_MASK 3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define EDT_REF_FREQ_KHZ 13560
`define EDT_SYS_PERIOD_NS 100
`define EDT_PHASE_UNIT 32'h000003E8
`define EDT_PHASE_STEP ((`EDT_REF_FREQ_KHZ * `EDT_SYS_PERIOD_NS) / 1000)
`define EDT_EXP_MAX 5'h15

`endif

// ### hw/edt_prescaler.v
/*
 Tick generator: one pulse every two to the exponent reference cycles,
 the 13.56 MHz reference being tracked by a phase accumulator on clk_sys_i.
 Assumes a 10 MHz system clock; a tick can come at most once per cycle.
*/
`timescale 1ns/1ns
`include "edt_map.vh"

module edt_prescaler (
    // Clock and reset
    input wire clk_sys_i,
    input wire nrst_i,
    // Control
    input wire clear_i,
    input wire [4:0] exp_i,
    // Tick
    output reg tick_o
);

reg [31:0] phase;
wire [4:0] exp_lim;
wire [31:0] period;
wire [31:0] sum;
wire [31:0] rem;

// ----------------------------------------
// Period in thousandths of a reference cycle
// ----------------------------------------
assign exp_lim = (exp_i > `EDT_EXP_MAX) ? `EDT_EXP_MAX : exp_i;
assign period = `EDT_PHASE_UNIT << exp_lim;
assign sum = phase + `EDT_PHASE_STEP;
assign rem = sum - period;

always @(posedge clk_sys_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        phase <= 32'h00000000;
        tick_o <= 1'b0;
    end
    else if (clear_i)
    begin
        phase <= 32'h00000000;
        tick_o <= 1'b0;
    end
    else if (sum >= period)
    begin
        phase <= (rem >= period) ? 32'h00000000 : rem;
        tick_o <= 1'b1;
    end
    else
    begin
        phase <= sum;
        tick_o <= 1'b0;
    end
end

endmodule

// ### hw/edt_flag_bank.v
/*
 Sticky event flags, cleared by writing a one; a set wins over a clear.
 Assumes set and clear vectors are one-cycle pulses on clk_sys_i.
*/
`timescale 1ns/1ns
`include "edt_map.vh"

module edt_flag_bank (
    // Clock and reset
    input wire clk_sys_i,
    input wire nrst_i,
    // Events and clears
    input wire [`EDT_IRQ_WIDTH-1:0] set_i,
    input wire [`EDT_IRQ_WIDTH-1:0] clr_i,
    // Flags
    output wire [`EDT_IRQ_WIDTH-1:0] flag_o
);

reg [`EDT_IRQ_WIDTH-1:0] flag;

assign flag_o = flag;

// ----------------------------------------
// One flip-flop per event
// ----------------------------------------
genvar i;
generate
    for (i = 0; i < `EDT_IRQ_WIDTH; i = i + 1)
    begin : g_flag
        always @(posedge clk_sys_i or negedge nrst_i)
        begin
            if (!nrst_i)
                flag[i] <= 1'b0;
            else if (set_i[i])
                flag[i] <= 1'b1;
            else if (clr_i[i])
                flag[i] <= 1'b0;
        end
    end
endgenerate

endmodule

// ### verif/edt_timer_properties.sv
/*
 Port checker for the down timer.
 Assumes it is bound to edt_timer; one clock, async active-low reset.
*/
`timescale 1ns/1ns

module edt_timer_chk (
    // Clock and reset
    input wire clk_sys_i,
    input wire nrst_i,
    // Register port
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    // Events
    input wire tx_begin_i,
    input wire tx_end_i,
    input wire rx_begin_i,
    input wire rx_end_i,
    // State
    input wire [7:0] current_count_o,
    input wire count_active_o,
    input wire irq_o
);
// ----
// Register shadows
// ----
reg [7:0] sv;
reg [5:0] cfg;
reg [3:0] trg;
wire quiet = !wr_i && !tx_begin_i && !tx_end_i && !rx_begin_i && !rx_end_i;
wire go = (tx_begin_i && trg[0]) || (tx_end_i && trg[1]) || (rx_begin_i && trg[2]);

always @(posedge clk_sys_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        sv <= 8'h0A;
        cfg <= 6'h07;
        trg <= 4'h6;
    end
    else if (wr_i)
    begin
        if (addr_i == 8'h2C)
            sv <= wdata_i;
        if (addr_i == 8'h2A)
            cfg <= wdata_i[5:0];
        if (addr_i == 8'h2B)
            trg <= wdata_i[3:0];
    end
end

// ----
// Properties
// ----
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!nrst_i);

count_step_a: assert property (count_active_o && quiet && current_count_o > 8'h01 |=>
    current_count_o == $past(current_count_o) || current_count_o == $past(current_count_o) - 8'h01)
    else $error("count moved by more than one");
idle_hold_a: assert property (!count_active_o && quiet |=>
    $stable(current_count_o) && !count_active_o) else $error("idle count changed");
end_count_a: assert property ($fell(count_active_o) && !$past(wr_i) && !$past(rx_end_i) |->
    current_count_o == 8'h00 && !$past(cfg[5])) else $error("bad end of count");
read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read cycle");
read_count_a: assert property (rd_i && addr_i == 8'h0C |=>
    rdata_o == $past(current_count_o)) else $error("count read wrong");
start_load_a: assert property (wr_i && addr_i == 8'h09 && wdata_i[1:0] == 2'b01
    && !(rx_end_i && trg[3]) |=> count_active_o && current_count_o == $past(sv))
    else $error("start did not load");
stop_now_a: assert property (wr_i && addr_i == 8'h09 && wdata_i[1] |=>
    !count_active_o) else $error("stop ignored");
event_start_a: assert property (go && !(rx_end_i && trg[3]) && !wr_i |=>
    count_active_o && current_count_o == $past(sv)) else $error("event start failed");
event_stop_a: assert property (rx_end_i && trg[3] |=> !count_active_o)
    else $error("receive end did not stop");
reload_one_a: assert property (count_active_o && quiet && cfg[5]
    && current_count_o == 8'h01 |=> count_active_o
    && (current_count_o == 8'h01 || current_count_o == $past(sv)))
    else $error("auto reload failed");
endmodule

bind edt_timer edt_timer_chk edt_timer_chk_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_begin_i(tx_begin_i),
    .tx_end_i(tx_end_i), .rx_begin_i(rx_begin_i), .rx_end_i(rx_end_i),
    .current_count_o(current_count_o), .count_active_o(count_active_o), .irq_o(irq_o)
);

// ### verif/tb_edt_timer.sv
/*
 Self-checking bench for the down timer.
 Assumes the design under hw/ and the bound port checker.
*/
`timescale 1ns/1ns

module tb_edt_timer;
reg clk_sys_i;
reg nrst_i;
reg [7:0] addr;
reg [7:0] wd;
reg wr;
reg rd;
reg [3:0] ev;
wire [7:0] rdata;
wire [7:0] cnt;
wire act;
wire irq;
reg [7:0] v;
integer bad_count;
integer n_checks;
integer cyc;
integer i;
integer n;

edt_timer edt_timer_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wd), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .tx_begin_i(ev[0]), .tx_end_i(ev[1]), .rx_begin_i(ev[2]),
    .rx_end_i(ev[3]), .current_count_o(cnt), .count_active_o(act), .irq_o(irq)
);

initial
begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
end

// ----
// Helpers
// ----
task test_done;
begin
    if (bad_count == 0 && n_checks > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
end
endtask

task chk(input [7:0] seen, input [7:0] exp, input string nm);
begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
        bad_count = bad_count + 1;
        $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
end
endtask

task wr8(input [7:0] a, input [7:0] d);
begin
    @(posedge clk_sys_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
end
endtask

task rd8(input [7:0] a);
begin
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(negedge clk_sys_i);
    v = rdata;
end
endtask

task rc(input [7:0] a, input [7:0] e, input string nm);
begin
    rd8(a);
    chk(v, e, nm);
end
endtask

task pulse(input integer k);
begin
    @(posedge clk_sys_i);
    ev <= 4'h1 << k;
    @(posedge clk_sys_i);
    ev <= 4'h0;
    @(negedge clk_sys_i);
end
endtask

// ----
// Scenarios
// ----
task t_reset;
begin
    rc(8'h0C, 8'h05, "count");
    rc(8'h2A, 8'h07, "clk cfg");
    rc(8'h2B, 8'h06, "trigger");
    rc(8'h2C, 8'h0A, "start val");
    rc(8'h32, 8'h00, "mask");
    rc(8'h7F, 8'h00, "unmapped");
    wr8(8'h0C, 8'h33);
    rc(8'h0C, 8'h05, "count ro");
end
endtask

task t_count;
begin
    wr8(8'h2A, 8'h00);
    wr8(8'h2C, 8'h03);
    wr8(8'h31, 8'h07);
    wr8(8'h32, 8'h01);
    wr8(8'h09, 8'h01);
    @(negedge clk_sys_i);
    chk({7'h00, act}, 8'h01, "running");
    n = 0;
    while (act !== 1'b0 && n < 50)
    begin
        @(negedge clk_sys_i);
        n = n + 1;
    end
    chk({7'h00, act}, 8'h00, "ended");
    chk(cnt, 8'h00, "end count");
    repeat (2) @(negedge clk_sys_i);
    chk({7'h00, irq}, 8'h01, "irq");
    rd8(8'h31);
    chk(v & 8'h01, 8'h01, "zero flag");
    wr8(8'h32, 8'h00);
    repeat (2) @(negedge clk_sys_i);
    chk({7'h00, irq}, 8'h00, "masked irq");
    wr8(8'h31, 8'h07);
    rd8(8'h31);
    chk(v & 8'h01, 8'h00, "cleared");
end
endtask

task t_tick;
begin
    wr8(8'h2A, 8'h04);
    wr8(8'h2C, 8'hFF);
    wr8(8'h09, 8'h01);
    @(negedge clk_sys_i);
    v = cnt;
    n = 0;
    while (cnt === v && n < 100)
    begin
        @(negedge clk_sys_i);
        n = n + 1;
    end
    v = cnt;
    n = 0;
    while (cnt === v && n < 100)
    begin
        @(negedge clk_sys_i);
        n = n + 1;
    end
    chk(cnt, v - 8'h01, "step");
    chk((n >= 11 && n <= 12) ? 8'h01 : 8'h00, 8'h01, "tick len");
    wr8(8'h09, 8'h02);
    @(negedge clk_sys_i);
    v = cnt;
    repeat (30) @(negedge clk_sys_i);
    chk(cnt, v, "frozen");
    chk({7'h00, act}, 8'h00, "stopped");
end
endtask

task t_restart;
begin
    wr8(8'h2A, 8'h20);
    wr8(8'h2C, 8'h02);
    wr8(8'h09, 8'h01);
    n = 0;
    repeat (20) @(negedge clk_sys_i) n = n + ((cnt !== 8'h01 && cnt !== 8'h02) || act !== 1'b1);
    chk(n[7:0], 8'h00, "reload");
    wr8(8'h09, 8'h02);
end
endtask

task t_events;
begin
    wr8(8'h2A, 8'h07);
    wr8(8'h2B, 8'h0F);
    wr8(8'h2C, 8'h40);
    for (i = 0; i < 3; i = i + 1)
    begin
        pulse(i);
        chk({7'h00, act}, 8'h01, "ev start");
        chk(cnt, 8'h40, "ev load");
        pulse(3);
        chk({7'h00, act}, 8'h00, "ev stop");
    end
    wr8(8'h2B, 8'h00);
    pulse(0);
    chk({7'h00, act}, 8'h00, "disabled");
end
endtask

task t_rerst;
begin
    wr8(8'h31, 8'h07);
    wr8(8'h09, 8'h01);
    rc(8'h30, 8'h01, "status run");
    rc(8'h31, 8'h02, "start flag");
    wr8(8'h09, 8'h02);
    rc(8'h31, 8'h06, "stop flag");
    rc(8'h30, 8'h00, "status idle");
    wr8(8'h09, 8'h01);
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(negedge clk_sys_i);
    chk(cnt, 8'h05, "rst count");
    chk({7'h00, act}, 8'h00, "rst run");
    rc(8'h31, 8'h00, "rst flags");
    rc(8'h2C, 8'h0A, "rst start val");
end
endtask

initial
begin
    nrst_i = 1'b0;
    addr = 8'h00;
    wd = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ev = 4'h0;
    bad_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_reset;
    t_count;
    t_tick;
    t_restart;
    t_events;
    t_rerst;
    test_done;
end

always @(posedge clk_sys_i)
begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
        bad_count = bad_count + 1;
        test_done;
    end
end
endmodule
